// File: rtl/smsc_controller.sv
// Controller end: APB slave that runs one sixteen-bit serial frame per command.
`timescale 1ns/10ps
module smsc_controller (
	input wire logic CLK_SYS,
	input wire logic RESET,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Serial link.
	smsc_if.ctl LINK
);
	smsc_pkg::smsc_state_t state;
	logic [15:0] tx;
	logic [7:0] rx;
	logic [5:0] div;
	logic [4:0] bits;
	logic tick;
	logic apb_wr;
	logic known;

	assign tick = (div == smsc_pkg::SCK_DIV - 6'h01);
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign known = (PADDR == smsc_pkg::APB_CMD) | (PADDR == smsc_pkg::APB_STATUS)
		| (PADDR == smsc_pkg::APB_RDATA);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~known;

	always_comb begin
		case (PADDR)
			smsc_pkg::APB_STATUS: PRDATA = {31'h0000_0000, state != smsc_pkg::SMSC_IDLE};
			smsc_pkg::APB_RDATA: PRDATA = {24'h00_0000, rx};
			default: PRDATA = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET || state == smsc_pkg::SMSC_IDLE || tick) begin
			div <= 6'h00;
		end else begin
			div <= div + 6'h01;
		end
	end

	// Command word: bit 15 access, 14:8 address, 7:0 data; reserved data bits go as given.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state <= smsc_pkg::SMSC_IDLE;
			tx <= 16'h0000;
			rx <= 8'h00;
			bits <= 5'h00;
			LINK.csn <= 1'b1;
			LINK.sck <= 1'b0;
			LINK.mosi <= 1'b0;
		end else begin
			case (state)
				smsc_pkg::SMSC_IDLE: begin
					if (apb_wr && PADDR == smsc_pkg::APB_CMD) begin
						tx <= {PWDATA[14:0], 1'b0};
						LINK.mosi <= PWDATA[15];
						LINK.csn <= 1'b0;
						bits <= 5'h00;
						state <= smsc_pkg::SMSC_SHIFT;
					end
				end
				smsc_pkg::SMSC_SHIFT: begin
					if (tick) begin
						if (!LINK.sck) begin
							LINK.sck <= 1'b1;
							if (bits >= 5'h08) begin
								rx <= {rx[6:0], LINK.miso};
							end
							bits <= bits + 5'h01;
						end else begin
							LINK.sck <= 1'b0;
							if (bits == 5'(smsc_pkg::FRAME_BITS)) begin
								state <= smsc_pkg::SMSC_DONE;
							end else begin
								LINK.mosi <= tx[15];
								tx <= {tx[14:0], 1'b0};
							end
						end
					end
				end
				smsc_pkg::SMSC_DONE: begin
					if (tick) begin
						LINK.csn <= 1'b1;
						state <= smsc_pkg::SMSC_IDLE;
					end
				end
				default: state <= smsc_pkg::SMSC_IDLE;
			endcase
		end
	end
endmodule

// File: rtl/smsc_device.sv
// Register bank end: serial slave holding mode, supply and hardware control bytes.
`timescale 1ns/10ps
module smsc_device (
	input wire logic CLK_SYS,
	input wire logic RESET,
	// Serial link.
	smsc_if.dev LINK,
	// Device events.
	input wire logic RESTART_ENTER,
	input wire logic OVERTEMP_EVENT,
	input wire logic RAIL1_OV_EVENT,
	input wire logic WDOG_FAIL_EVENT,
	input wire logic FAILURE_FLAG,
	input wire logic IN_STOP,
	input wire logic IN_NORMAL,
	input wire logic IN_FAILSAFE,
	// Control outputs.
	output logic [1:0] MODE_REQUEST,
	output logic SOFT_RESET_PULSE,
	output logic RESET_OUTPUT_PIN_N,
	output logic SECOND_RAIL_ON,
	output logic [1:0] MAIN_RAIL_RESET_THRESHOLD,
	output logic MAIN_RAIL_OVERVOLTAGE_FLAG,
	output logic ESCALATE_REQUEST,
	output logic FAILURE_OUTPUT_PINS
);
	logic [7:0] mode_supply;
	logic [7:0] hardware_control;
	logic [15:0] shift_in;
	logic [7:0] shift_out;
	logic [4:0] bit_cnt;
	logic sck_d;
	logic wd_fail_seen;
	logic [1:0] rail_field;
	logic [6:0] addr;
	logic [6:0] rd_addr;
	logic [7:0] rd_byte;
	logic rise;
	logic fall;
	logic frame_end;
	logic wr_frame;
	logic [1:0] req_mode;
	logic soft_reset_now;

	assign rise = LINK.sck & ~sck_d;
	assign fall = ~LINK.sck & sck_d;
	// Bits arrive MSB first, so the command byte lands in the upper half.
	assign addr = shift_in[14:8];
	// The reply byte is picked after only eight bits, while the command byte still sits low.
	assign rd_addr = shift_in[6:0];
	assign wr_frame = (bit_cnt == 5'(smsc_pkg::FRAME_BITS)) & shift_in[15];
	assign frame_end = LINK.csn & ~sck_d & (bit_cnt == 5'(smsc_pkg::FRAME_BITS));
	assign req_mode = shift_in[smsc_pkg::MODE_HI:smsc_pkg::MODE_LO];
	assign soft_reset_now = frame_end & wr_frame & (addr == smsc_pkg::ADDR_MODE_SUPPLY)
		& (req_mode == smsc_pkg::MODE_SOFT_RESET);

	always_comb begin
		case (rd_addr)
			smsc_pkg::ADDR_MODE_SUPPLY: rd_byte = mode_supply;
			smsc_pkg::ADDR_HARDWARE_CONTROL: rd_byte = hardware_control;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			sck_d <= 1'b0;
		end else begin
			sck_d <= LINK.sck;
		end
	end

	// Frame receive: sample on rising clock edge, MSB first.
	always_ff @(posedge CLK_SYS) begin
		if (RESET || LINK.csn) begin
			bit_cnt <= smsc_pkg::BIT_CNT_INIT;
		end else if (rise && bit_cnt != 5'(smsc_pkg::FRAME_BITS)) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			shift_in <= 16'h0000;
		end else if (!LINK.csn && rise && bit_cnt != 5'(smsc_pkg::FRAME_BITS)) begin
			shift_in <= {shift_in[14:0], LINK.mosi};
		end
	end

	// The data byte out is loaded after the command byte, before any write lands,
	// so a write frame returns the content programmed before it.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			shift_out <= 8'h00;
		end else if (!LINK.csn && fall && bit_cnt == 5'h08) begin
			shift_out <= rd_byte;
		end else if (!LINK.csn && fall && bit_cnt > 5'h08) begin
			shift_out <= {shift_out[6:0], 1'b0};
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			LINK.miso <= 1'b0;
		end else if (!LINK.csn && fall && bit_cnt == 5'h08) begin
			LINK.miso <= rd_byte[7];
		end else if (!LINK.csn && fall && bit_cnt > 5'h08) begin
			LINK.miso <= shift_out[6];
		end else if (LINK.csn) begin
			LINK.miso <= 1'b0;
		end
	end

	// Mode and supply control byte.
	always_ff @(posedge CLK_SYS) begin
		if (RESET || soft_reset_now) begin
			mode_supply <= smsc_pkg::MODE_SUPPLY_POR;
		end else if (RESTART_ENTER) begin
			// Threshold bits survive a restart; mode goes normal, rail off.
			mode_supply[smsc_pkg::MODE_HI:smsc_pkg::MODE_LO] <= smsc_pkg::MODE_NORMAL;
			mode_supply[smsc_pkg::RAIL_HI:smsc_pkg::RAIL_LO] <= smsc_pkg::RAIL_OFF;
			mode_supply[smsc_pkg::OV_EN_BIT] <= 1'b0;
		end else begin
			if (frame_end && wr_frame && addr == smsc_pkg::ADDR_MODE_SUPPLY) begin
				// Reserved bit is masked off.
				mode_supply <= (shift_in[7:0] & smsc_pkg::MODE_SUPPLY_WMASK);
				if (mode_supply[smsc_pkg::MODE_HI:smsc_pkg::MODE_LO] == smsc_pkg::MODE_STOP
					&& req_mode == smsc_pkg::MODE_SLEEP) begin
					mode_supply[smsc_pkg::MODE_HI:smsc_pkg::MODE_LO] <= smsc_pkg::MODE_STOP;
				end
			end
			if (OVERTEMP_EVENT) begin
				mode_supply[smsc_pkg::RAIL_HI:smsc_pkg::RAIL_LO] <= smsc_pkg::RAIL_OFF;
			end
		end
	end

	// Hardware control byte.
	always_ff @(posedge CLK_SYS) begin
		if (RESET || soft_reset_now) begin
			hardware_control <= smsc_pkg::HARDWARE_CONTROL_POR;
		end else if (RESTART_ENTER) begin
			hardware_control[smsc_pkg::FO_SW_BIT] <= 1'b0;
		end else if (frame_end && wr_frame && addr == smsc_pkg::ADDR_HARDWARE_CONTROL) begin
			hardware_control <= shift_in[7:0] & smsc_pkg::HARDWARE_CONTROL_WMASK;
		end
	end

	// Watchdog escalation: with config bit low, the second failure escalates.
	always_ff @(posedge CLK_SYS) begin
		if (RESET || RESTART_ENTER) begin
			wd_fail_seen <= 1'b0;
			ESCALATE_REQUEST <= 1'b0;
		end else begin
			ESCALATE_REQUEST <= 1'b0;
			if (WDOG_FAIL_EVENT) begin
				wd_fail_seen <= 1'b1;
				if (wd_fail_seen && !hardware_control[smsc_pkg::CFG_BIT]) begin
					ESCALATE_REQUEST <= 1'b1;
				end
			end
			if (RAIL1_OV_EVENT && mode_supply[smsc_pkg::OV_EN_BIT]) begin
				ESCALATE_REQUEST <= 1'b1;
			end
		end
	end

	// Overvoltage flag is sticky and set regardless of the enable bit.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			MAIN_RAIL_OVERVOLTAGE_FLAG <= 1'b0;
		end else if (RAIL1_OV_EVENT) begin
			MAIN_RAIL_OVERVOLTAGE_FLAG <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SOFT_RESET_PULSE <= 1'b0;
			RESET_OUTPUT_PIN_N <= 1'b0;
		end else begin
			SOFT_RESET_PULSE <= soft_reset_now;
			RESET_OUTPUT_PIN_N <= ~(soft_reset_now & ~hardware_control[smsc_pkg::SRO_SUPPRESS_BIT]);
		end
	end

	assign rail_field = mode_supply[smsc_pkg::RAIL_HI:smsc_pkg::RAIL_LO];
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SECOND_RAIL_ON <= 1'b0;
			MODE_REQUEST <= smsc_pkg::MODE_NORMAL;
			MAIN_RAIL_RESET_THRESHOLD <= 2'h0;
			FAILURE_OUTPUT_PINS <= 1'b0;
		end else begin
			case (rail_field)
				2'h1: SECOND_RAIL_ON <= IN_NORMAL;
				2'h2: SECOND_RAIL_ON <= IN_NORMAL | IN_STOP;
				2'h3: SECOND_RAIL_ON <= ~IN_FAILSAFE;
				default: SECOND_RAIL_ON <= 1'b0;
			endcase
			MODE_REQUEST <= mode_supply[smsc_pkg::MODE_HI:smsc_pkg::MODE_LO];
			MAIN_RAIL_RESET_THRESHOLD <= mode_supply[smsc_pkg::THR_HI:smsc_pkg::THR_LO];
			FAILURE_OUTPUT_PINS <= hardware_control[smsc_pkg::FO_SW_BIT] | FAILURE_FLAG;
		end
	end
endmodule

// File: rtl/smsc_if.sv
// Four-wire serial link between the controller and the register bank.
`timescale 1ns/10ps
interface smsc_if;
	logic csn;
	logic sck;
	logic mosi;
	logic miso;
	modport dev (input csn, input sck, input mosi, output miso);
	modport ctl (output csn, output sck, output mosi, input miso);
endinterface

// File: rtl/smsc_pkg.sv
// Shared constants and types for the mode and supply control register bank.
package smsc_pkg;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 7;
	localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
	localparam logic [6:0] ADDR_HARDWARE_CONTROL = 7'h02;
	localparam logic [7:0] MODE_SUPPLY_POR = 8'h00;
	localparam logic [7:0] HARDWARE_CONTROL_POR = 8'h00;
	localparam logic [7:0] MODE_SUPPLY_WMASK = 8'hDF;
	localparam logic [7:0] HARDWARE_CONTROL_WMASK = 8'h61;
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int RAIL_HI = 4;
	localparam int RAIL_LO = 3;
	localparam int OV_EN_BIT = 2;
	localparam int THR_HI = 1;
	localparam int THR_LO = 0;
	localparam int SRO_SUPPRESS_BIT = 6;
	localparam int FO_SW_BIT = 5;
	localparam int CFG_BIT = 0;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_STOP = 2'h2;
	localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
	localparam logic [1:0] RAIL_OFF = 2'h0;
	localparam logic [5:0] SCK_DIV = 6'h04;
	localparam logic [4:0] BIT_CNT_INIT = 5'h00;
	// APB map of the controller.
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_RDATA = 8'h08;
	typedef enum logic [1:0] {SMSC_IDLE, SMSC_SHIFT, SMSC_DONE} smsc_state_t;
endpackage

// File: verif/smsc_chk.sv
// Assertions on the serial link that joins the controller to the register bank.
`timescale 1ns/10ps
module smsc_chk (
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RESET,
	// Serial link.
	input wire logic csn,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso
);
	logic sck_q;
	logic [4:0] rises;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Rising clock edges are counted per frame so a short frame is caught at its end.
	always_ff @(posedge CLK_SYS) begin
		sck_q <= sck;
		if (RESET || csn) rises <= 5'h00;
		else if (sck && !sck_q) rises <= rises + 5'h01;
	end
	property p_idle; csn |-> !sck; endproperty
	a_idle: assert property (p_idle) else $error("serial clock moves outside a frame");
	property p_high; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
	a_high: assert property (p_high) else $error("serial clock high phase wrong");
	property p_low; $fell(sck) |-> !sck[*4]; endproperty
	a_low: assert property (p_low) else $error("serial clock low phase too short");
	property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
	a_mosi: assert property (p_mosi) else $error("command data moved while sampled");
	property p_miso; sck && $past(sck) |-> $stable(miso); endproperty
	a_miso: assert property (p_miso) else $error("reply data moved while sampled");
	property p_count; $rose(csn) |-> rises == 5'h10; endproperty
	a_count: assert property (p_count) else $error("frame is not sixteen bits");
	property p_gap; $rose(csn) |=> csn; endproperty
	a_gap: assert property (p_gap) else $error("frames too close");
	property p_len; $fell(csn) |-> ##[100:300] $rose(csn); endproperty
	a_len: assert property (p_len) else $error("frame never ends");
endmodule

// File: verif/tb.sv
// Self-checking bench: controller and register bank joined over the serial link.
`timescale 1ns/10ps
module tb;
	typedef struct {logic [15:0] cmd; logic [7:0] exp;} smsc_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic pready, pslverr, slv, srst, ro_n, rail_on, ov, esc, fo;
	logic [3:0] ev = 4'h0;
	logic [2:0] lvl = 3'h2;
	logic fail = 1'b0;
	logic [1:0] mode_req, thr;
	logic [7:0] b;
	int err_total = 0, n_compared = 0, ro_low = 0, n_esc = 0, n_srst = 0, base;
	smsc_row_t rows[10] = '{'{16'h0100, 8'h00}, '{16'h0200, 8'h00}, '{16'h813F, 8'h00},
		'{16'h0100, 8'h1F}, '{16'h82FF, 8'h00}, '{16'h0200, 8'h61}, '{16'h8260, 8'h61},
		'{16'h0260, 8'h60}, '{16'h8555, 8'h00}, '{16'h0500, 8'h00}};
	smsc_if link();
	smsc_controller smsc_controller_i (.CLK_SYS(clk), .RESET(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LINK(link.ctl));
	smsc_device smsc_device_i (.CLK_SYS(clk), .RESET(rst), .LINK(link.dev),
		.RESTART_ENTER(ev[0]), .OVERTEMP_EVENT(ev[1]), .RAIL1_OV_EVENT(ev[2]),
		.WDOG_FAIL_EVENT(ev[3]), .FAILURE_FLAG(fail), .IN_STOP(lvl[0]), .IN_NORMAL(lvl[1]),
		.IN_FAILSAFE(lvl[2]), .MODE_REQUEST(mode_req), .SOFT_RESET_PULSE(srst),
		.RESET_OUTPUT_PIN_N(ro_n), .SECOND_RAIL_ON(rail_on), .MAIN_RAIL_RESET_THRESHOLD(thr),
		.MAIN_RAIL_OVERVOLTAGE_FLAG(ov), .ESCALATE_REQUEST(esc), .FAILURE_OUTPUT_PINS(fo));
	smsc_chk smsc_chk_i (.CLK_SYS(clk), .RESET(rst), .csn(link.csn), .sck(link.sck),
		.mosi(link.mosi), .miso(link.miso));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Pulse counters; reset-output counts are taken as differences, since the pin leaves reset low.
	always @(posedge clk) begin
		if (!rst && ro_n === 1'b0) ro_low++;
		if (esc === 1'b1) n_esc++;
		if (srst === 1'b1) n_srst++;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic xfer(input logic [15:0] cmd);
		int n;
		apb(1'b1, smsc_pkg::APB_CMD, {16'h0000, cmd});
		n = 0;
		do begin
			apb(1'b0, smsc_pkg::APB_STATUS, 32'h0000_0000);
			n++;
		end while (r[0] !== 1'b0 && n < 400);
		chk(8'(r[0]), 8'h00, "frame never finished");
		apb(1'b0, smsc_pkg::APB_RDATA, 32'h0000_0000);
		b = r[7:0];
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= 4'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic results;
		if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		results;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			xfer(rows[i].cmd);
			chk(b, rows[i].exp, "register byte");
		end
		chk(8'(rail_on), 8'h01, "second rail");
		chk(8'(thr), 8'h03, "threshold");
		chk(8'(fo), 8'h01, "failure output");
		lvl <= 3'h4;
		repeat (2) @(posedge clk);
		chk(8'(rail_on), 8'h00, "rail off in fail-safe");
		lvl <= 3'h2;
		xfer(16'h819F);
		chk(8'(mode_req), 8'h02, "mode request");
		lvl <= 3'h1;
		xfer(16'h815F);
		xfer(16'h0100);
		chk(b, 8'h9F, "stop to sleep");
		pulse(1);
		xfer(16'h0100);
		chk(b, 8'h87, "overtemperature");
		pulse(0);
		lvl <= 3'h2;
		xfer(16'h0100);
		chk(b, 8'h03, "restart mode byte");
		xfer(16'h0200);
		chk(b, 8'h40, "restart hardware byte");
		chk(8'(fo), 8'h00, "failure output after restart");
		chk(8'(rail_on), 8'h00, "rail after restart");
		fail <= 1'b1;
		repeat (2) @(posedge clk);
		chk(8'(fo), 8'h01, "failure drives outputs");
		fail <= 1'b0;
		pulse(3);
		chk(8'(n_esc), 8'h00, "early escalation");
		pulse(3);
		chk(8'(n_esc), 8'h01, "escalation");
		pulse(2);
		chk(8'(ov), 8'h01, "overvoltage flag");
		chk(8'(n_esc), 8'h01, "reaction with enable low");
		xfer(16'h8107);
		chk(b, 8'h03, "previous content on write");
		pulse(2);
		chk(8'(n_esc), 8'h02, "reaction with enable high");
		base = ro_low;
		xfer(16'h81C0);
		chk(8'(ro_low - base), 8'h00, "suppressed reset output");
		xfer(16'h0200);
		chk(b, 8'h00, "soft reset value");
		xfer(16'h81C0);
		chk(8'(ro_low - base), 8'h01, "reset output pulse");
		chk(8'(n_srst), 8'h02, "soft reset pulses");
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(8'(slv), 8'h01, "unmapped bus access");
		// A second reset in mid-run must clear the sticky flag and the hardware control byte.
		xfer(16'h8261);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		chk(8'(ro_n), 8'h00, "reset output in reset");
		rst <= 1'b0;
		chk(8'(ov), 8'h00, "flag after reset");
		xfer(16'h0200);
		chk(b, 8'h00, "hardware byte after reset");
		results;
	end
endmodule
